// ==== hw/urp_programmer.sv ====
// Programmer that drives a 32K x 8 UV ROM through its pins
//
// Contract
// - Program needs high supply, chip low, output high
// - Whole byte driven in parallel when programming
// - Pulses last 100 us, only as needed
// - Verify after each pulse, retry to limit
// - Each address pulsed at raised main supply
// - Final whole-array verify at nominal supplies
// - Any address order or subset allowed
// - Verify read: output low, chip high
`include "urp_params.svh"
`default_nettype none
module urp_programmer
    import urp_pkg::*;
#(
    parameter int ADDR_W = `URP_ADDR_W,
    parameter int DATA_W = `URP_DATA_W,
    parameter int PULSE_CYC = `URP_PULSE_CYC,
    parameter int SETTLE_CYC = `URP_SETTLE_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Job interface: one word per request
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire urp_req_t req_i,
    input wire logic [7:0] max_pulses_i,
    input wire logic last_i,
    // Result per word and whole job
    output logic word_done_o,
    output logic word_fail_o,
    output logic [7:0] pulses_used_o,
    output logic job_done_o,
    output logic job_pass_o,
    // Memory pins
    output logic chip_en_n_o,
    output logic out_en_n_o,
    output logic [ADDR_W-1:0] word_select_lines_o,
    input wire logic [DATA_W-1:0] byte_pins_i,
    output logic [DATA_W-1:0] byte_pins_o,
    output logic byte_pins_oe_o,
    output urp_supply_t supply_sel_o
);
    localparam int TW = 16;

    typedef enum {
        S_IDLE, S_SETUP, S_PULSE, S_RDSET, S_CMP, S_DONE
    } urp_state_t;

    typedef struct packed {
        urp_state_t state;
        logic cen_n;
        logic oen_n;
        logic [14:0] addr;
        logic [7:0] data;
        logic [7:0] dout;
        logic doe;
        logic verify_only;
        logic last;
        logic [7:0] pulses;
        logic [DATA_W-1:0] sync1;
        logic [DATA_W-1:0] sync2;
        urp_supply_t supply;
        logic word_done;
        logic word_fail;
        logic job_done;
        logic job_ok;
        logic tstart;
        logic [TW-1:0] tload;
    } urp_st_t;

    urp_st_t st_q, st_d;
    logic tdone;

    // Readback matches only when every bit equals the wanted byte
    function automatic logic urp_match(input logic [7:0] rd,
                                       input logic [7:0] want);
        urp_match = (rd == want);
    endfunction : urp_match

    // Shared timer for pulse width and settle waits
    urp_pulse_timer #(.CNT_W(TW)) u_tmr (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .start_i(st_q.tstart),
        .load_i(st_q.tload),
        .done_o(tdone)
    );

    // Sequencer
    always_comb begin
        st_d = st_q;
        st_d.sync1 = byte_pins_i;
        st_d.sync2 = st_q.sync1;
        st_d.word_done = 1'b0;
        st_d.word_fail = 1'b0;
        st_d.job_done = 1'b0;
        st_d.tstart = 1'b0;
        case (st_q.state)
            S_IDLE: begin
                // Fresh job only after the last end has been reported
                if (st_q.job_done) begin
                    st_d.job_ok = 1'b1;
                end
                st_d.cen_n = 1'b1;
                st_d.oen_n = 1'b1;
                st_d.doe = 1'b0;
                if (req_valid_i) begin
                    st_d.addr = req_i.addr;
                    st_d.data = req_i.data;
                    st_d.verify_only = req_i.verify_only;
                    st_d.last = last_i;
                    st_d.pulses = 8'h00;
                    st_d.supply = req_i.verify_only ? URP_SUP_VERIFY
                                                    : URP_SUP_PROG;
                    st_d.tstart = 1'b1;
                    st_d.tload = TW'(SETTLE_CYC);
                    st_d.state = S_SETUP;
                end
            end
            S_SETUP: begin
                if (tdone) begin
                    if (st_q.verify_only
                        || st_q.data == `URP_ERASED_BYTE) begin
                        // Erased byte needs no pulse, just read it
                        // Final verify: both enables low; else chip high
                        st_d.cen_n = !st_q.verify_only;
                        st_d.oen_n = 1'b0;
                        st_d.tstart = 1'b1;
                        st_d.tload = TW'(SETTLE_CYC);
                        st_d.state = S_RDSET;
                    end else begin
                        st_d.dout = st_q.data;
                        st_d.doe = 1'b1;
                        st_d.oen_n = 1'b1;
                        st_d.cen_n = 1'b0;
                        st_d.pulses = st_q.pulses + 8'h01;
                        st_d.tstart = 1'b1;
                        // Timer start and stop add a cycle each
                        st_d.tload = TW'(PULSE_CYC - 2);
                        st_d.state = S_PULSE;
                    end
                end
            end
            S_PULSE: begin
                if (tdone) begin
                    // Release data bus, chip high and output low all in the same cycle
                    st_d.cen_n = 1'b1;
                    st_d.doe = 1'b0;
                    st_d.oen_n = 1'b0;
                    st_d.tstart = 1'b1;
                    st_d.tload = TW'(SETTLE_CYC);
                    st_d.state = S_RDSET;
                end
            end
            S_RDSET: begin
                if (tdone) begin
                    st_d.tstart = 1'b1;
                    st_d.tload = TW'(3); // Let the synchroniser fill
                    st_d.state = S_CMP;
                end
            end
            S_CMP: begin
                if (tdone) begin
                    st_d.oen_n = 1'b1;
                    st_d.cen_n = 1'b1;
                    if (urp_match(st_q.sync2, st_q.data)) begin
                        st_d.word_done = 1'b1;
                        st_d.state = S_DONE;
                    end else if (st_q.verify_only
                                 || st_q.pulses >= max_pulses_i) begin
                        st_d.word_done = 1'b1;
                        st_d.word_fail = 1'b1;
                        st_d.job_ok = 1'b0;
                        st_d.state = S_DONE;
                    end else begin
                        st_d.tstart = 1'b1;
                        st_d.tload = TW'(SETTLE_CYC);
                        st_d.state = S_SETUP;
                    end
                end
            end
            S_DONE: begin
                if (st_q.last) begin
                    st_d.job_done = 1'b1;
                    st_d.supply = URP_SUP_READ;
                end
                st_d.state = S_IDLE;
            end
            default: st_d.state = S_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= '0;
            st_q.state <= S_IDLE;
            st_q.cen_n <= 1'b1;
            st_q.oen_n <= 1'b1;
            st_q.job_ok <= 1'b1;
            st_q.supply <= URP_SUP_READ;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs
    assign req_ready_o = (st_q.state == S_IDLE);
    assign word_done_o = st_q.word_done;
    assign word_fail_o = st_q.word_fail;
    assign pulses_used_o = st_q.pulses;
    assign job_done_o = st_q.job_done;
    assign job_pass_o = st_q.job_done & st_q.job_ok;
    assign chip_en_n_o = st_q.cen_n;
    assign out_en_n_o = st_q.oen_n;
    assign word_select_lines_o = st_q.addr;
    assign byte_pins_o = st_q.dout;
    assign byte_pins_oe_o = st_q.doe;
    assign supply_sel_o = st_q.supply;
endmodule : urp_programmer
`default_nettype wire

// ==== hw/urp_params.svh ====
// Timing counts, widths, limits and the erased byte value for the UV ROM programmer
`ifndef URP_PARAMS_SVH
`define URP_PARAMS_SVH
`define URP_ADDR_W 15
`define URP_DATA_W 8
`define URP_CLK_MHZ 50
`define URP_PULSE_US 100
`define URP_PULSE_CYC (`URP_PULSE_US * `URP_CLK_MHZ)
`define URP_SETTLE_CYC 5
`define URP_MAX_PULSES 25
`define URP_ERASED_BYTE 8'hFF
`endif

// ==== hw/urp_pkg.sv ====
// Types shared by the UV ROM programmer
`default_nettype none
package urp_pkg;
    // Supply levels requested from the external regulators
    typedef enum logic [1:0] {
        URP_SUP_READ,
        URP_SUP_PROG,
        URP_SUP_VERIFY
    } urp_supply_t;

    // Control pins towards the memory
    typedef struct packed {
        logic chip_en_n;
        logic out_en_n;
        logic [14:0] word_select_lines;
        logic [7:0] byte_pins_out;
        logic byte_pins_oe;
    } urp_pins_t;

    // Job request from the user side
    typedef struct packed {
        logic [14:0] addr;
        logic [7:0] data;
        logic verify_only;
    } urp_req_t;
endpackage : urp_pkg
`default_nettype wire

// ==== hw/urp_pulse_timer.sv ====
// Countdown timer used for program pulses and settle waits
`default_nettype none
module urp_pulse_timer #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic start_i,
    input wire logic [CNT_W-1:0] load_i,
    output logic done_o
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic busy;
        logic done;
    } urp_tmr_t;
    urp_tmr_t st_q, st_d;

    // Count down, pulse done once at expiry
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        if (start_i) begin
            st_d.cnt = load_i;
            st_d.busy = 1'b1;
        end else if (st_q.busy) begin
            if (st_q.cnt <= CNT_W'(1)) begin
                st_d.busy = 1'b0;
                st_d.done = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt - CNT_W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign done_o = st_q.done;
endmodule : urp_pulse_timer
`default_nettype wire

// ==== bench/urp_programmer_properties.sv ====
// Pin order and timing properties of the UV ROM programmer
`default_nettype none
module urp_programmer_properties
    import urp_pkg::*;
#(
    parameter int PULSE_CYC = 5000
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Job results
    input wire logic [7:0] max_pulses_i,
    input wire logic word_done_o,
    input wire logic word_fail_o,
    input wire logic [7:0] pulses_used_o,
    input wire logic job_done_o,
    input wire logic job_pass_o,
    // Memory pins
    input wire logic chip_en_n_o,
    input wire logic out_en_n_o,
    input wire logic [14:0] word_select_lines_o,
    input wire logic [7:0] byte_pins_o,
    input wire logic byte_pins_oe_o,
    input wire urp_supply_t supply_sel_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] hi_q;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Length of the current drive window, cleared when it ends
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) hi_q <= 16'h0000;
        else hi_q <= byte_pins_oe_o ? hi_q + 16'h0001 : 16'h0000;
    end
    property p_prog_pins;
        byte_pins_oe_o |-> supply_sel_o == URP_SUP_PROG && !chip_en_n_o
            && out_en_n_o;
    endproperty
    a_prog_pins: assert property (p_prog_pins)
        else $error("pulse without program conditions");
    property p_pulse_len;
        $fell(byte_pins_oe_o) |-> hi_q == PULSE_CYC;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("pulse length wrong");
    property p_data_hold;
        byte_pins_oe_o && $past(byte_pins_oe_o) |-> $stable(byte_pins_o)
            && $stable(word_select_lines_o);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("byte or address moved in pulse");
    property p_readback;
        $fell(byte_pins_oe_o) |-> ##[0:20] (!out_en_n_o && chip_en_n_o);
    endproperty
    a_readback: assert property (p_readback)
        else $error("no read-back after pulse");
    property p_verify_mode;
        supply_sel_o == URP_SUP_PROG && !out_en_n_o |-> chip_en_n_o;
    endproperty
    a_verify_mode: assert property (p_verify_mode)
        else $error("read at high supply with chip low");
    property p_final_read;
        !chip_en_n_o && !out_en_n_o |-> supply_sel_o == URP_SUP_VERIFY;
    endproperty
    a_final_read: assert property (p_final_read)
        else $error("plain read not at verify supply");
    property p_fail_limit;
        word_fail_o |-> word_done_o && pulses_used_o <= max_pulses_i;
    endproperty
    a_fail_limit: assert property (p_fail_limit)
        else $error("failure flag off its word");
    property p_job_pass;
        job_pass_o |-> job_done_o && $past(word_done_o);
    endproperty
    a_job_pass: assert property (p_job_pass)
        else $error("job pass out of place");
endmodule : urp_programmer_properties
bind urp_programmer urp_programmer_properties #(.PULSE_CYC(PULSE_CYC))
    u_props (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .max_pulses_i(max_pulses_i), .word_done_o(word_done_o),
    .word_fail_o(word_fail_o), .pulses_used_o(pulses_used_o),
    .job_done_o(job_done_o), .job_pass_o(job_pass_o),
    .chip_en_n_o(chip_en_n_o), .out_en_n_o(out_en_n_o),
    .word_select_lines_o(word_select_lines_o),
    .byte_pins_o(byte_pins_o), .byte_pins_oe_o(byte_pins_oe_o),
    .supply_sel_o(supply_sel_o));
`default_nettype wire

// ==== bench/urp_rom_model.sv ====
// Behavioural 32K x 8 UV ROM seen from its pins
`default_nettype none
module urp_rom_model
    import urp_pkg::*;
(
    // Pins from the programmer
    input wire logic core_clk_i,
    input wire logic chip_en_n_i,
    input wire logic out_en_n_i,
    input wire logic [14:0] word_select_lines_i,
    input wire logic [7:0] data_i,
    input wire urp_supply_t supply_i,
    // Pulses a cell needs before it takes
    input wire logic [7:0] need_i,
    // Data towards the programmer
    output logic [7:0] byte_pins_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:32767];
    logic [7:0] last_q = 8'hFF, hits_q = 8'h00, dat_q = 8'hFF;
    logic [14:0] adr_q = 15'h0000;
    logic prog_q = 1'b0;
    logic prog, drive;
    // Erased cells read all ones
    initial for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
    // Mode decode; released pins show the inverse of the last byte
    assign prog = supply_i == URP_SUP_PROG && !chip_en_n_i && out_en_n_i;
    assign drive = !out_en_n_i && (!chip_en_n_i || supply_i == URP_SUP_PROG);
    assign byte_pins_o = drive ? mem[word_select_lines_i] : ~last_q;
    // A pulse takes effect at its end, only clearing bits
    always @(posedge core_clk_i) begin
        prog_q <= prog;
        adr_q <= word_select_lines_i;
        if (prog) dat_q <= data_i;
        if (adr_q != word_select_lines_i) hits_q <= 8'h00;
        else if (prog_q && !prog) begin
            hits_q <= hits_q + 8'h01;
            if (hits_q + 8'h01 >= need_i) mem[adr_q] <= mem[adr_q] & dat_q;
        end
        if (drive) last_q <= byte_pins_o;
    end
endmodule : urp_rom_model
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the UV ROM programmer
`default_nettype none
module tb;
    import urp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0, reset_n_i = 1'b0, req_valid_i = 1'b0;
    logic last_i = 1'b0, req_ready_o, word_done_o, word_fail_o;
    logic job_done_o, job_pass_o, chip_en_n_o, out_en_n_o, byte_pins_oe_o;
    logic [7:0] max_pulses_i = 8'h01, need = 8'h01, pulses_used_o;
    logic [7:0] byte_pins_i, byte_pins_o, rom_q;
    logic [14:0] word_select_lines_o;
    urp_req_t req_i = '0;
    urp_supply_t supply_sel_o;
    int mismatches = 0, tests_run = 0, cyc = 0;
    // Shared data wire: whoever enables drives it
    assign byte_pins_i = byte_pins_oe_o ? byte_pins_o : rom_q;
    urp_programmer #(.PULSE_CYC(20)) dut (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o),
        .req_i(req_i),
        .max_pulses_i(max_pulses_i),
        .last_i(last_i),
        .word_done_o(word_done_o),
        .word_fail_o(word_fail_o),
        .pulses_used_o(pulses_used_o),
        .job_done_o(job_done_o),
        .job_pass_o(job_pass_o),
        .chip_en_n_o(chip_en_n_o),
        .out_en_n_o(out_en_n_o),
        .word_select_lines_o(word_select_lines_o),
        .byte_pins_i(byte_pins_i),
        .byte_pins_o(byte_pins_o),
        .byte_pins_oe_o(byte_pins_oe_o),
        .supply_sel_o(supply_sel_o)
    );
    urp_rom_model rom (.core_clk_i(core_clk_i), .chip_en_n_i(chip_en_n_o),
        .out_en_n_i(out_en_n_o), .word_select_lines_i(word_select_lines_o),
        .data_i(byte_pins_i), .supply_i(supply_sel_o), .need_i(need),
        .byte_pins_o(rom_q));
    // Clock and hang guard
    always #10 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    // One word: request held until taken, then judged at word end
    task automatic word(input logic [14:0] a, input logic [7:0] d,
            input logic v, l, input logic [7:0] nd, mx, np,
            input logic fl, ps);
        int n;
        @(posedge core_clk_i);
        need <= nd;
        max_pulses_i <= mx;
        req_i <= '{a, d, v};
        last_i <= l;
        req_valid_i <= 1'b1;
        n = 0;
        do @(negedge core_clk_i); while (req_ready_o !== 1'b1 && ++n < 50);
        @(posedge core_clk_i);
        req_valid_i <= 1'b0;
        n = 0;
        do @(negedge core_clk_i); while (word_done_o !== 1'b1 && ++n < 2000);
        chk(word_done_o, 1'b1);
        chk(word_fail_o, fl);
        chk(pulses_used_o, np);
        chk(word_select_lines_o, a);
        // Job end pulses only after the last word
        @(negedge core_clk_i);
        chk(job_done_o, l);
        chk(job_pass_o, l & ps);
    endtask : word
    task automatic s_idle;
        @(negedge core_clk_i);
        chk({chip_en_n_o, out_en_n_o, byte_pins_oe_o, req_ready_o}, 4'hD);
        chk(supply_sel_o, URP_SUP_READ);
    endtask : s_idle
    task automatic s_erased;
        word(15'h7FFF, 8'hFF, 1, 0, 1, 4, 0, 0, 0);
        word(15'h0000, 8'h00, 1, 1, 1, 4, 0, 1, 0);
    endtask : s_erased
    task automatic s_prog_once;
        word(15'h1234, 8'hA5, 0, 0, 1, 4, 1, 0, 0);
        word(15'h1234, 8'hA5, 1, 0, 1, 4, 0, 0, 0);
    endtask : s_prog_once
    task automatic s_retry;
        word(15'h4000, 8'h0F, 0, 0, 3, 5, 3, 0, 0);
    endtask : s_retry
    task automatic s_limit;
        word(15'h0001, 8'h00, 0, 0, 9, 4, 4, 1, 0);
        word(15'h0002, 8'h3C, 0, 0, 2, 1, 1, 1, 0);
    endtask : s_limit
    task automatic s_no_undo;
        word(15'h1234, 8'h5A, 0, 1, 1, 2, 2, 1, 0);
    endtask : s_no_undo
    task automatic s_job_pass;
        word(15'h7FFE, 8'hC3, 0, 0, 1, 3, 1, 0, 0);
        word(15'h0100, 8'hFF, 0, 1, 1, 3, 0, 0, 1);
    endtask : s_job_pass
    // Main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        s_idle;
        s_erased;
        s_prog_once;
        s_retry;
        s_limit;
        s_no_undo;
        s_job_pass;
        report_and_stop;
    end
endmodule : tb
`default_nettype wire
